/* File: core/irc_pkg.sv */
// Shared constants and carrier types for the IR resource configuration bank
package irc_pkg;

  // ---------------------------------------------------------------
  // Configuration indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_ROUTE = 8'h29;
  localparam logic [7:0] IDX_RSVD_2A = 8'h2A;
  localparam logic [7:0] IDX_FIR_BASE = 8'h2B;
  localparam logic [7:0] IDX_FIR_DMA = 8'h2C;
  localparam logic [7:0] IDX_HD_TIMEOUT = 8'h2D;
  localparam logic [7:0] IDX_SSEL_A = 8'h2E;
  localparam logic [7:0] IDX_SSEL_B = 8'h2F;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_RSVD_2A = 8'h00;
  localparam logic [7:0] RST_FIR_BASE = 8'h00;
  localparam logic [7:0] RST_FIR_DMA = 8'h00;
  localparam logic [7:0] RST_HD_TIMEOUT = 8'h03;
  localparam logic [7:0] RST_SSEL = 8'h00;
  localparam logic [7:0] RST_INDEX = 8'h00;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int ROUTE_IRQ_LSB = 0;
  localparam int ROUTE_MODE_BIT = 4;
  localparam int ROUTE_RSVD_BIT = 5;
  localparam int ROUTE_SIRQ_BIT = 7;
  localparam logic [7:0] ROUTE_WR_MASK = 8'hDF;
  localparam logic [7:0] DMA_WR_MASK = 8'h0F;
  localparam int BASE_HI_LSB = 5;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [3:0] DMA_SEL_LAST = 4'h3;
  localparam int NUM_IRQ = 16;
  localparam int NUM_DMA = 4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int HD_UNIT_NS = 100000;
  localparam int HD_TICK_CYCLES = HD_UNIT_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic in_cfg;
    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } irc_host_req_t;

  typedef struct packed {
    logic timeout_wr;
    logic ssel_a_wr;
    logic ssel_b_wr;
    logic [7:0] wdata;
  } irc_ir_req_t;

endpackage : irc_pkg

/* File: core/irc_hd_timer.sv */
// Half-duplex turnaround timer counting 100 us units
`timescale 1ns/1ns
module irc_hd_timer #(
  parameter int TICK_CYCLES = irc_pkg::HD_TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [7:0] timeout_i,
  output logic busy_o,
  output logic done_o
);

  logic [12:0] tick;
  logic [7:0] units;
  logic tick_end;

  assign tick_end = (tick == 13'(TICK_CYCLES - 1));

  // ---------------------------------------------------------------
  // Unit counter: value times 100 us
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tick <= 13'h0000;
      units <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        // Zero time-out expires at once
        tick <= 13'h0000;
        units <= timeout_i;
        busy_o <= (timeout_i != 8'h00);
        done_o <= (timeout_i == 8'h00);
      end else if (busy_o) begin
        if (tick_end) begin
          tick <= 13'h0000;
          units <= units - 8'h01;
          if (units == 8'h01) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end else begin
          tick <= tick + 13'h0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_hd_zero;
    ce_i && start_i && timeout_i == 8'h00 |=> done_o && !busy_o;
  endproperty
  a_hd_zero: assert property (p_hd_zero)
    else $error("zero time-out did not expire at once");

endmodule : irc_hd_timer

/* File: core/irc_cfg_regs.sv */
// IR resource configuration register bank, indices 29h to 2Fh
// ---------------------------------------------------------------
// Summary of operation
// - Route register reachable only in config at 29h
// - Bits 3:0 route interrupt input to IRQ
// - Code 0 no line, 1-15 lines 1-15
// - Unselected IRQ outputs stay high impedance
// - Bit 4 picks IR output mode path
// - Bit 5 ignores writes, reads zero
// - Bit 7 set disables serial IRQ
// - Index 2Ah reserved, holds zero
// - Fast-IR base holds address bits 10:3
// - Base bits 10:8 zero disables decode
// - Chip select low; A2:0 pass through
// - DMA field 0-3 selects A-D, else none
// - DMA bits 7:4 ignore writes, read zero
// - Unselected DMA requests stay high impedance
// - Turnaround time-out resets to 03h, read/write
// - Time-out is value times 100 us
// - Config and controller time-out copies mirror
// - Controller soft reset leaves time-out alone
// - Select A shared with controller block 3/05h
// - Select B shared with controller block 3/06h
// ---------------------------------------------------------------
`timescale 1ns/1ns
module irc_cfg_regs #(
  parameter int HD_TICK_CYCLES = irc_pkg::HD_TICK_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire irc_pkg::irc_host_req_t host_i,
  output logic [7:0] cfg_rdata_o,
  input wire irc_pkg::irc_ir_req_t ir_i,
  output logic [7:0] hd_timeout_o,
  output logic [7:0] software_select_a_o,
  output logic [7:0] software_select_b_o,
  input wire logic hd_start_i,
  output logic hd_busy_o,
  output logic hd_done_o,
  input wire logic ext_irq_input_i,
  output logic [15:1] irq_o,
  output logic [15:1] irq_oe_o,
  output logic ir_output_mode_sel_o,
  output logic serial_irq_enable_o,
  input wire logic chip_select_n_i,
  input wire logic [10:0] addr_i,
  output logic fast_ir_engine_sel_o,
  output logic [2:0] fast_ir_engine_reg_o,
  input wire logic fir_drq_i,
  output logic [3:0] dma_request_out_o,
  output logic [3:0] dma_request_out_oe_o
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] irc_irq_decode(input logic [3:0] code);
    logic [15:0] hot;
    hot = 16'h0000;
    hot[code] = 1'b1;
    hot[0] = 1'b0;
    return hot;
  endfunction : irc_irq_decode

  function automatic logic [3:0] irc_dma_decode(input logic [3:0] code);
    logic [3:0] hot;
    hot = 4'h0;
    if (code <= irc_pkg::DMA_SEL_LAST) begin
      hot[code[1:0]] = 1'b1;
    end
    return hot;
  endfunction : irc_dma_decode

  function automatic logic irc_hit(input logic [7:0] idx,
                                   input logic [7:0] want);
    return idx == want;
  endfunction : irc_hit

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] index;
  logic [7:0] route;
  logic [7:0] rsvd_2a;
  logic [7:0] fir_base;
  logic [7:0] fir_dma;
  logic [7:0] hd_timeout;
  logic [7:0] ssel_a;
  logic [7:0] ssel_b;
  logic cfg_wr;
  logic [7:0] next_rdata;
  logic [15:0] irq_hot;
  logic fir_enabled;

  // Data strokes count only inside configuration state
  assign cfg_wr = host_i.in_cfg && host_i.data_wr;

  // ---------------------------------------------------------------
  // Index register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      index <= irc_pkg::RST_INDEX;
    end else if (ce_i && host_i.in_cfg && host_i.idx_wr) begin
      index <= host_i.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt routing and mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      route <= irc_pkg::RST_ROUTE;
    end else if (ce_i && cfg_wr && irc_hit(index, irc_pkg::IDX_ROUTE)) begin
      // Bit 5 never stored
      route <= host_i.wdata & irc_pkg::ROUTE_WR_MASK;
    end
  end

  // Reserved slot: keeps its reset value, writes dropped
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rsvd_2a <= irc_pkg::RST_RSVD_2A;
    end
  end

  // ---------------------------------------------------------------
  // Fast-IR base and DMA select
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fir_base <= irc_pkg::RST_FIR_BASE;
    end else if (ce_i && cfg_wr && irc_hit(index, irc_pkg::IDX_FIR_BASE)) begin
      fir_base <= host_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fir_dma <= irc_pkg::RST_FIR_DMA;
    end else if (ce_i && cfg_wr && irc_hit(index, irc_pkg::IDX_FIR_DMA)) begin
      fir_dma <= host_i.wdata & irc_pkg::DMA_WR_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Mirrored turnaround time-out
  // ---------------------------------------------------------------
  // One storage serves both views, so the copies can never drift.
  // Only the device reset touches it; the controller soft reset is
  // not wired here at all.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      hd_timeout <= irc_pkg::RST_HD_TIMEOUT;
    end else if (ce_i) begin
      if (cfg_wr && irc_hit(index, irc_pkg::IDX_HD_TIMEOUT)) begin
        hd_timeout <= host_i.wdata;
      end else if (ir_i.timeout_wr) begin
        hd_timeout <= ir_i.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software select bytes shared with the IR controller
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ssel_a <= irc_pkg::RST_SSEL;
    end else if (ce_i) begin
      if (cfg_wr && irc_hit(index, irc_pkg::IDX_SSEL_A)) begin
        ssel_a <= host_i.wdata;
      end else if (ir_i.ssel_a_wr) begin
        ssel_a <= ir_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ssel_b <= irc_pkg::RST_SSEL;
    end else if (ce_i) begin
      if (cfg_wr && irc_hit(index, irc_pkg::IDX_SSEL_B)) begin
        ssel_b <= host_i.wdata;
      end else if (ir_i.ssel_b_wr) begin
        ssel_b <= ir_i.wdata;
      end
    end
  end

  assign hd_timeout_o = hd_timeout;
  assign software_select_a_o = ssel_a;
  assign software_select_b_o = ssel_b;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    case (index)
      irc_pkg::IDX_ROUTE: next_rdata = route;
      irc_pkg::IDX_RSVD_2A: next_rdata = rsvd_2a;
      irc_pkg::IDX_FIR_BASE: next_rdata = fir_base;
      irc_pkg::IDX_FIR_DMA: next_rdata = fir_dma;
      irc_pkg::IDX_HD_TIMEOUT: next_rdata = hd_timeout;
      irc_pkg::IDX_SSEL_A: next_rdata = ssel_a;
      irc_pkg::IDX_SSEL_B: next_rdata = ssel_b;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o <= 8'h00;
    end else if (ce_i && host_i.in_cfg && host_i.data_rd) begin
      cfg_rdata_o <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // IRQ routing and mode outputs
  // ---------------------------------------------------------------
  assign irq_hot = irc_irq_decode(route[irc_pkg::ROUTE_IRQ_LSB +: 4]);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_o <= 15'h0000;
      irq_oe_o <= 15'h0000;
    end else if (ce_i) begin
      // Only the chosen line is driven; the rest float
      irq_o <= {15{ext_irq_input_i}} & irq_hot[15:1];
      irq_oe_o <= irq_hot[15:1];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ir_output_mode_sel_o <= 1'b0;
      serial_irq_enable_o <= 1'b1;
    end else if (ce_i) begin
      ir_output_mode_sel_o <= route[irc_pkg::ROUTE_MODE_BIT];
      serial_irq_enable_o <= !route[irc_pkg::ROUTE_SIRQ_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Fast-IR address decode
  // ---------------------------------------------------------------
  assign fir_enabled = (fir_base[7:irc_pkg::BASE_HI_LSB] != 3'h0);
  // Low three address bits are not compared
  assign fast_ir_engine_sel_o = fir_enabled && !chip_select_n_i
                                && (addr_i[10:3] == fir_base);
  assign fast_ir_engine_reg_o = addr_i[2:0];

  // ---------------------------------------------------------------
  // Fast-IR DMA request steering
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dma_request_out_o <= 4'h0;
      dma_request_out_oe_o <= 4'h0;
    end else if (ce_i) begin
      // Reserved codes steer nowhere, same as none
      dma_request_out_o <= {4{fir_drq_i}} & irc_dma_decode(fir_dma[3:0]);
      dma_request_out_oe_o <= irc_dma_decode(fir_dma[3:0]);
    end
  end

  // ---------------------------------------------------------------
  // Turnaround timer
  // ---------------------------------------------------------------
  irc_hd_timer #(
    .TICK_CYCLES(HD_TICK_CYCLES)
  ) u_hd_timer (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .start_i(hd_start_i),
    .timeout_i(hd_timeout),
    .busy_o(hd_busy_o),
    .done_o(hd_done_o)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_cfg_wr(logic [7:0] idx);
    ce_i && host_i.in_cfg && host_i.data_wr && index == idx;
  endsequence

  property p_reset_vals;
    $fell(sys_rst_i) |-> route == 8'h00 && hd_timeout == 8'h03
                         && fir_base == 8'h00 && ssel_a == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("register reset values wrong");

  property p_route_guard;
    ce_i && !(host_i.in_cfg && host_i.data_wr && index == 8'h29)
      |=> $stable(route);
  endproperty
  a_route_guard: assert property (p_route_guard)
    else $error("route changed without a config write");

  property p_rsvd_zero;
    route[5] == 1'b0 && fir_dma[7:4] == 4'h0 && rsvd_2a == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits hold a one");

  property p_irq_route;
    ce_i ##1 ce_i |=> irq_oe_o == $past(irq_hot[15:1], 1)
                      && irq_o == ($past(irq_hot[15:1], 1)
                                   & {15{$past(ext_irq_input_i, 1)}});
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("IRQ line not the routed one");

  property p_irq_none;
    ce_i && route[3:0] == 4'h0 |=> irq_oe_o == 15'h0000;
  endproperty
  a_irq_none: assert property (p_irq_none)
    else $error("IRQ driven with no line chosen");

  property p_mode_bits;
    ce_i |=> ir_output_mode_sel_o == $past(route[4])
             && serial_irq_enable_o == !$past(route[7]);
  endproperty
  a_mode_bits: assert property (p_mode_bits)
    else $error("mode or serial IRQ output wrong");

  property p_fir_off;
    fir_base[7:5] == 3'h0 |-> !fast_ir_engine_sel_o;
  endproperty
  a_fir_off: assert property (p_fir_off)
    else $error("fast-IR decoded while disabled");

  property p_fir_sel;
    fast_ir_engine_sel_o |-> !chip_select_n_i && addr_i[10:3] == fir_base;
  endproperty
  a_fir_sel: assert property (p_fir_sel)
    else $error("fast-IR select without address match");

  property p_dma_none;
    ce_i && fir_dma[3:0] > 4'h3 |=> dma_request_out_oe_o == 4'h0;
  endproperty
  a_dma_none: assert property (p_dma_none)
    else $error("DMA driven with no channel chosen");

  property p_mirror;
    ce_i && ir_i.timeout_wr && !(host_i.in_cfg && host_i.data_wr
                                 && index == 8'h2D)
      |=> hd_timeout == $past(ir_i.wdata) ##0 hd_timeout_o == hd_timeout;
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("controller write missed the mirror");

  property p_ssel_a;
    s_cfg_wr(8'h2E) |=> software_select_a_o == $past(host_i.wdata);
  endproperty
  a_ssel_a: assert property (p_ssel_a)
    else $error("select A not updated by config write");

  property p_ssel_b;
    s_cfg_wr(8'h2F) |=> software_select_b_o == $past(host_i.wdata);
  endproperty
  a_ssel_b: assert property (p_ssel_b)
    else $error("select B not updated by config write");

endmodule : irc_cfg_regs

/* File: verification/irc_host_model.sv */
// Host model driving configuration index and data strokes
`timescale 1ns/1ns
module irc_host_model (
  input wire logic clk_sys_i,
  input wire logic [7:0] cfg_rdata_i,
  output irc_pkg::irc_host_req_t host_o
);
  initial host_o = '0;

  // ---------------------------------------------------------------
  // Strokes
  // ---------------------------------------------------------------
  // Set after a falling edge, held over one rising edge
  task automatic stroke(input logic iw, input logic dw, input logic dr,
                        input logic [7:0] d);
    @(negedge clk_sys_i);
    host_o.idx_wr = iw;
    host_o.data_wr = dw;
    host_o.data_rd = dr;
    host_o.wdata = d;
    @(negedge clk_sys_i);
    host_o.idx_wr = 1'b0;
    host_o.data_wr = 1'b0;
    host_o.data_rd = 1'b0;
    // Released bus never keeps the last byte
    host_o.wdata = ~d;
  endtask : stroke

  task automatic set_cfg(input logic on);
    @(negedge clk_sys_i);
    host_o.in_cfg = on;
  endtask : set_cfg

  // Index first, then one data transfer
  task automatic access(input logic [7:0] idx, input logic wr,
                        input logic [7:0] d, output logic [7:0] q);
    stroke(1'b1, 1'b0, 1'b0, idx);
    stroke(1'b0, wr, ~wr, d);
    q = cfg_rdata_i;
  endtask : access
endmodule : irc_host_model

/* File: verification/ir_resource_config_regs_tb.sv */
// Self-checking bench for the IR resource configuration bank
`timescale 1ns/1ns
module ir_resource_config_regs_tb;
  localparam int TICK = 4;
  logic clk_sys_i, sys_rst_i, ce_i, hd_start_i, ext_irq;
  logic cs_n, fir_drq, busy, done, mode, serial_irq_disable_n, fsel;
  logic [10:0] addr;
  irc_pkg::irc_host_req_t host;
  irc_pkg::irc_ir_req_t ir;
  logic [7:0] rdata, hd_to, ssa, ssb, rv;
  logic [2:0] freg;
  logic [15:1] irq, irq_oe, exp_irq;
  logic [3:0] dma_request_out, drq_oe, exp_dma;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt;

  irc_cfg_regs #(.HD_TICK_CYCLES(TICK)) u_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .host_i(host), .cfg_rdata_o(rdata), .ir_i(ir), .hd_timeout_o(hd_to),
    .software_select_a_o(ssa), .software_select_b_o(ssb),
    .hd_start_i(hd_start_i), .hd_busy_o(busy), .hd_done_o(done),
    .ext_irq_input_i(ext_irq), .irq_o(irq), .irq_oe_o(irq_oe),
    .ir_output_mode_sel_o(mode), .serial_irq_enable_o(serial_irq_disable_n),
    .chip_select_n_i(cs_n), .addr_i(addr), .fast_ir_engine_sel_o(fsel),
    .fast_ir_engine_reg_o(freg), .fir_drq_i(fir_drq),
    .dma_request_out_o(dma_request_out), .dma_request_out_oe_o(drq_oe)
  );

  irc_host_model u_host (
    .clk_sys_i(clk_sys_i), .cfg_rdata_i(rdata), .host_o(host)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // Run is about 350 cycles; a hang stops well past that
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Access helpers
  // ---------------------------------------------------------------
  // Extra edge lets register-derived outputs settle
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    u_host.access(idx, 1'b1, d, rv);
    @(negedge clk_sys_i);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    u_host.access(idx, 1'b0, 8'h00, rv);
    chk($sformatf("index %h", idx), 16'(rv), 16'(exp));
  endtask : rd

  task automatic ir_wr(input logic [2:0] sel, input logic [7:0] d);
    @(negedge clk_sys_i);
    ir = {sel, d};
    @(negedge clk_sys_i);
    // Strobes drop and data is scrambled in one assignment
    ir = {3'b000, ~d};
  endtask : ir_wr

  // Address moves on a falling edge, decode is read one cycle later
  task automatic probe(input logic [10:0] a, input logic hit);
    addr = a;
    @(negedge clk_sys_i);
    chk("decode hit", 16'(fsel), 16'(hit));
    chk("reg select", 16'(freg), 16'(a[2:0]));
  endtask : probe

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    hd_start_i = 1'b0;
    ext_irq = 1'b0;
    cs_n = 1'b1;
    fir_drq = 1'b0;
    addr = 11'h000;
    ir = '0;
    repeat (10) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    chk("serial irq enable", 16'(serial_irq_disable_n), 16'h0001);
    chk("irq enables", 16'(irq_oe), 16'h0000);
    chk("dma enables", 16'(drq_oe), 16'h0000);
    u_host.set_cfg(1'b1);
    rd(irc_pkg::IDX_ROUTE, 8'h00);
    rd(irc_pkg::IDX_RSVD_2A, 8'h00);
    rd(irc_pkg::IDX_FIR_BASE, 8'h00);
    rd(irc_pkg::IDX_FIR_DMA, 8'h00);
    rd(irc_pkg::IDX_HD_TIMEOUT, 8'h03);
    rd(irc_pkg::IDX_SSEL_A, 8'h00);
    rd(irc_pkg::IDX_SSEL_B, 8'h00);
    wr(irc_pkg::IDX_ROUTE, 8'hFF);
    rd(irc_pkg::IDX_ROUTE, 8'hDF);
    chk("serial irq enable", 16'(serial_irq_disable_n), 16'h0000);
    chk("output mode", 16'(mode), 16'h0001);
    wr(irc_pkg::IDX_ROUTE, 8'h00);
    chk("output mode", 16'(mode), 16'h0000);
    chk("serial irq enable", 16'(serial_irq_disable_n), 16'h0001);
    ext_irq = 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(irc_pkg::IDX_ROUTE, 8'(c));
      exp_irq = 15'((16'h0001 << c) >> 1);
      chk("irq enables", 16'(irq_oe), 16'(exp_irq));
      chk("irq levels", 16'(irq & irq_oe), 16'(exp_irq));
    end
    ext_irq = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk("irq levels", 16'(irq & irq_oe), 16'h0000);
    // Strokes outside configuration state or with clock held
    u_host.set_cfg(1'b0);
    wr(irc_pkg::IDX_ROUTE, 8'h80);
    u_host.set_cfg(1'b1);
    ce_i = 1'b0;
    wr(irc_pkg::IDX_ROUTE, 8'h90);
    ce_i = 1'b1;
    rd(irc_pkg::IDX_ROUTE, 8'h0F);
    wr(irc_pkg::IDX_RSVD_2A, 8'h55);
    rd(irc_pkg::IDX_RSVD_2A, 8'h00);
    wr(irc_pkg::IDX_FIR_BASE, 8'h20);
    rd(irc_pkg::IDX_FIR_BASE, 8'h20);
    cs_n = 1'b0;
    for (int a = 'h0F8; a < 'h110; a++) begin
      probe(11'(a), 1'((a >= 'h100) && (a < 'h108)));
    end
    cs_n = 1'b1;
    probe(11'h104, 1'b0);
    cs_n = 1'b0;
    wr(irc_pkg::IDX_FIR_BASE, 8'hFF);
    probe(11'h7F8, 1'b1);
    wr(irc_pkg::IDX_FIR_BASE, 8'h1F);
    probe(11'h0F8, 1'b0);
    wr(irc_pkg::IDX_FIR_DMA, 8'hF2);
    rd(irc_pkg::IDX_FIR_DMA, 8'h02);
    fir_drq = 1'b1;
    for (int c = 0; c < 16; c++) begin
      wr(irc_pkg::IDX_FIR_DMA, 8'(c));
      exp_dma = (c < 4) ? 4'(1 << c) : 4'h0;
      chk("dma enables", 16'(drq_oe), 16'(exp_dma));
      chk("dma levels", 16'(dma_request_out & drq_oe), 16'(exp_dma));
    end
    wr(irc_pkg::IDX_HD_TIMEOUT, 8'h05);
    chk("time-out copy", 16'(hd_to), 16'h0005);
    ir_wr(3'b100, 8'h07);
    rd(irc_pkg::IDX_HD_TIMEOUT, 8'h07);
    ir_wr(3'b010, 8'h3C);
    rd(irc_pkg::IDX_SSEL_A, 8'h3C);
    ir_wr(3'b001, 8'hC3);
    rd(irc_pkg::IDX_SSEL_B, 8'hC3);
    wr(irc_pkg::IDX_SSEL_A, 8'hA5);
    chk("select a", 16'(ssa), 16'h00A5);
    wr(irc_pkg::IDX_SSEL_B, 8'h5A);
    chk("select b", 16'(ssb), 16'h005A);
    // Turnaround length in edges after the start edge
    for (int n = 0; n < 3; n += 2) begin
      wr(irc_pkg::IDX_HD_TIMEOUT, 8'(n));
      hd_start_i = 1'b1;
      @(negedge clk_sys_i);
      hd_start_i = 1'b0;
      chk("turnaround busy", 16'(busy), 16'(n != 0));
      cnt = 0;
      while (done !== 1'b1 && cnt < 200) begin
        @(negedge clk_sys_i);
        cnt++;
      end
      chk("turnaround", 16'(cnt), 16'(n * TICK));
      chk("turnaround idle", 16'(busy), 16'h0000);
    end
    print_verdict();
  end
endmodule : ir_resource_config_regs_tb
